// ### rtl/spr_pkg.sv
// Offsets, field positions and reset values of the serial-port and R-divider registers
package spr_pkg;
   // Register offsets on the internal register access port
   localparam int unsigned SPR_ADDR_W          = 12;
   localparam logic [11:0] SPR_OFS_PORT_CFG    = 12'h000;
   localparam logic [11:0] SPR_OFS_READBACK    = 12'h004;
   localparam logic [11:0] SPR_OFS_VER_LOW     = 12'h005;
   localparam logic [11:0] SPR_OFS_VER_HIGH    = 12'h006;
   localparam logic [11:0] SPR_OFS_REF_A_LOW   = 12'h010;
   localparam logic [11:0] SPR_OFS_REF_A_HIGH  = 12'h011;
   localparam logic [11:0] SPR_OFS_REF_B_LOW   = 12'h012;
   localparam logic [11:0] SPR_OFS_REF_B_HIGH  = 12'h013;

   // Field positions
   localparam int unsigned SPR_BIT_UNIDIR      = 7;
   localparam int unsigned SPR_BIT_LSB_FIRST   = 6;
   localparam int unsigned SPR_BIT_SOFT_RESET  = 5;
   localparam int unsigned SPR_BIT_RB_BUFFERED = 0;

   // Divider geometry
   localparam int unsigned SPR_RATIO_W         = 10;

   // Values after reset
   localparam logic       SPR_RST_UNIDIR       = 1'b0;
   localparam logic       SPR_RST_LSB_FIRST    = 1'b0;
   localparam logic       SPR_RST_RB_BUFFERED  = 1'b0;
   localparam logic [7:0] SPR_RST_VER_LOW      = 8'h00;
   localparam logic [7:0] SPR_RST_VER_HIGH     = 8'h00;
   localparam logic [9:0] SPR_RST_RATIO        = 10'h000;
endpackage : spr_pkg

// ### rtl/spr_ref_divider.sv
// Reference R divider: one output pulse per N synchronised reference rising edges
module spr_ref_divider
   import spr_pkg::*;
#(
   parameter int unsigned RATIO_W = SPR_RATIO_W
) (
   // Clock and reset
   input  wire logic               i_clk_sys,
   input  wire logic               i_resetn,
   input  wire logic               i_soft_reset,
   // Reference pin and ratio
   input  wire logic               i_ref_pin,
   input  wire logic [RATIO_W-1:0] i_ratio,
   // Divided reference
   output logic                    o_div_pulse
);
   // Elaboration guard; a one-bit ratio cannot express any divide above one
   if (RATIO_W < 2) begin : g_bad_ratio_w
      $error("spr_ref_divider: RATIO_W must be at least 2");
   end

   logic               sync1_reg;
   logic               sync2_reg;
   logic               prev_reg;
   logic [RATIO_W-1:0] cnt_reg;
   logic [RATIO_W-1:0] eff_ratio;
   logic               edge_seen;

   // Two-stage synchroniser plus edge history
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         sync1_reg <= i_ref_pin;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   assign edge_seen = sync2_reg & ~prev_reg;
   // Zero and one both mean divide by one
   assign eff_ratio = (i_ratio <= RATIO_W'(1)) ? RATIO_W'(1) : i_ratio;

   // Edge counter; >= keeps it sane if the ratio shrinks mid-count
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_reg     <= '0;
         o_div_pulse <= 1'b0;
      end else if (i_soft_reset) begin
         cnt_reg     <= '0;
         o_div_pulse <= 1'b0;
      end else if (edge_seen) begin
         if (cnt_reg + RATIO_W'(1) >= eff_ratio) begin
            cnt_reg     <= '0;
            o_div_pulse <= 1'b1;
         end else begin
            cnt_reg     <= cnt_reg + RATIO_W'(1);
            o_div_pulse <= 1'b0;
         end
      end else begin
         o_div_pulse <= 1'b0;
      end
   end
endmodule // spr_ref_divider

// ### rtl/spr_regs.sv
// Serial-port configuration and reference R divider register bank
module spr_regs
   import spr_pkg::*;
(
   // Clock and reset
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_resetn,
   // Register access port from the serial protocol engine
   input  wire logic                  i_wr_en,
   input  wire logic                  i_rd_en,
   input  wire logic [SPR_ADDR_W-1:0] i_addr,
   input  wire logic [7:0]            i_wr_data,
   output logic      [7:0]            o_rd_data,
   input  wire logic                  i_io_update,
   // Port mode context
   input  wire logic                  i_i2c_mode,
   input  wire logic                  i_ref_b_independent,
   // Serial data pins
   input  wire logic                  i_read_drive,
   input  wire logic                  i_read_bit,
   output logic                       o_sdio_out,
   output logic                       o_sdio_oe,
   output logic                       o_serial_out_pin,
   output logic                       o_serial_out_pin_oe,
   // Mode outputs to the protocol engine
   output logic                       o_unidirectional_mode_select,
   output logic                       o_lsb_first,
   output logic                       o_soft_reset,
   output logic [15:0]                o_user_version_id,
   // Reference inputs and divided references
   input  wire logic                  i_reference_input_a,
   input  wire logic                  i_reference_input_b,
   output logic [SPR_RATIO_W-1:0]     o_ref_a_ratio,
   output logic [SPR_RATIO_W-1:0]     o_ref_b_ratio,
   output logic                       o_ref_a_div,
   output logic                       o_ref_b_div
);
   logic                   unidir_reg;
   logic                   lsb_first_reg;
   logic                   rb_buffered_reg;
   logic                   soft_reset_reg;
   logic [7:0]             ver_low_reg;
   logic [7:0]             ver_high_reg;
   logic [SPR_RATIO_W-1:0] ref_a_buf_reg;
   logic [SPR_RATIO_W-1:0] ref_b_buf_reg;
   logic [SPR_RATIO_W-1:0] ref_a_act_reg;
   logic [SPR_RATIO_W-1:0] ref_b_act_reg;
   logic [SPR_RATIO_W-1:0] ref_a_view;
   logic [SPR_RATIO_W-1:0] ref_b_view;
   logic [SPR_RATIO_W-1:0] ref_b_used;
   logic [7:0]             rd_data_next;
   logic                   cfg_wr;

   assign cfg_wr = i_wr_en && (i_addr == SPR_OFS_PORT_CFG);

   // Soft reset pulse; lasts one cycle, and the bit always reads back as zero
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         soft_reset_reg <= 1'b0;
      end else begin
         soft_reset_reg <= cfg_wr && i_wr_data[SPR_BIT_SOFT_RESET];
      end
   end

   assign o_soft_reset = soft_reset_reg;

   // Port configuration; only bits 7 and 6 are stored, the mirror is rebuilt
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         unidir_reg    <= SPR_RST_UNIDIR;
         lsb_first_reg <= SPR_RST_LSB_FIRST;
      end else if (soft_reset_reg) begin
         unidir_reg    <= SPR_RST_UNIDIR;
         lsb_first_reg <= SPR_RST_LSB_FIRST;
      end else if (cfg_wr) begin
         unidir_reg    <= i_wr_data[SPR_BIT_UNIDIR];
         lsb_first_reg <= i_wr_data[SPR_BIT_LSB_FIRST];
      end
   end

   // Mode bits mean nothing in two-wire mode
   assign o_unidirectional_mode_select = unidir_reg & ~i_i2c_mode;
   assign o_lsb_first                  = lsb_first_reg & ~i_i2c_mode;

   // Readback source and user version ID
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         rb_buffered_reg <= SPR_RST_RB_BUFFERED;
         ver_low_reg     <= SPR_RST_VER_LOW;
         ver_high_reg    <= SPR_RST_VER_HIGH;
      end else if (soft_reset_reg) begin
         rb_buffered_reg <= SPR_RST_RB_BUFFERED;
         ver_low_reg     <= SPR_RST_VER_LOW;
         ver_high_reg    <= SPR_RST_VER_HIGH;
      end else if (i_wr_en) begin
         if (i_addr == SPR_OFS_READBACK) begin
            rb_buffered_reg <= i_wr_data[SPR_BIT_RB_BUFFERED];
         end else if (i_addr == SPR_OFS_VER_LOW) begin
            ver_low_reg <= i_wr_data;
         end else if (i_addr == SPR_OFS_VER_HIGH) begin
            ver_high_reg <= i_wr_data;
         end
      end
   end

   // Version ID drives nothing inside; exported for the storage side only
   assign o_user_version_id = {ver_high_reg, ver_low_reg};

   // Shadow copies of the divider ratios, written by the host
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ref_a_buf_reg <= SPR_RST_RATIO;
         ref_b_buf_reg <= SPR_RST_RATIO;
      end else if (soft_reset_reg) begin
         ref_a_buf_reg <= SPR_RST_RATIO;
         ref_b_buf_reg <= SPR_RST_RATIO;
      end else if (i_wr_en) begin
         if (i_addr == SPR_OFS_REF_A_LOW) begin
            ref_a_buf_reg[7:0] <= i_wr_data;
         end else if (i_addr == SPR_OFS_REF_A_HIGH) begin
            ref_a_buf_reg[9:8] <= i_wr_data[1:0];
         end else if (i_addr == SPR_OFS_REF_B_LOW) begin
            ref_b_buf_reg[7:0] <= i_wr_data;
         end else if (i_addr == SPR_OFS_REF_B_HIGH) begin
            ref_b_buf_reg[9:8] <= i_wr_data[1:0];
         end
      end
   end

   // Active ratios; a write in the update cycle lands in the shadow only
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         ref_a_act_reg <= SPR_RST_RATIO;
         ref_b_act_reg <= SPR_RST_RATIO;
      end else if (soft_reset_reg) begin
         ref_a_act_reg <= SPR_RST_RATIO;
         ref_b_act_reg <= SPR_RST_RATIO;
      end else if (i_io_update) begin
         ref_a_act_reg <= ref_a_buf_reg;
         ref_b_act_reg <= ref_b_buf_reg;
      end
   end

   assign o_ref_a_ratio = ref_a_act_reg;
   assign o_ref_b_ratio = ref_b_act_reg;

   // Readback view selection for buffered registers
   assign ref_a_view = rb_buffered_reg ? ref_a_buf_reg : ref_a_act_reg;
   assign ref_b_view = rb_buffered_reg ? ref_b_buf_reg : ref_b_act_reg;

   // Read decode; reserved bits and unmapped offsets read zero
   always_comb begin
      rd_data_next = 8'h00;
      if (i_addr == SPR_OFS_PORT_CFG) begin
         rd_data_next = {unidir_reg, lsb_first_reg, 2'b00,
                         2'b00, lsb_first_reg, unidir_reg};
      end else if (i_addr == SPR_OFS_READBACK) begin
         rd_data_next = {7'h00, rb_buffered_reg};
      end else if (i_addr == SPR_OFS_VER_LOW) begin
         rd_data_next = ver_low_reg;
      end else if (i_addr == SPR_OFS_VER_HIGH) begin
         rd_data_next = ver_high_reg;
      end else if (i_addr == SPR_OFS_REF_A_LOW) begin
         rd_data_next = ref_a_view[7:0];
      end else if (i_addr == SPR_OFS_REF_A_HIGH) begin
         rd_data_next = {6'h00, ref_a_view[9:8]};
      end else if (i_addr == SPR_OFS_REF_B_LOW) begin
         rd_data_next = ref_b_view[7:0];
      end else if (i_addr == SPR_OFS_REF_B_HIGH) begin
         rd_data_next = {6'h00, ref_b_view[9:8]};
      end
   end

   // Read data register; holds between reads
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rd_data <= 8'h00;
      end else if (i_rd_en) begin
         o_rd_data <= rd_data_next;
      end
   end

   // Data pin steering; registered, so pins follow the engine one cycle late
   always_ff @(posedge i_clk_sys or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sdio_out          <= 1'b0;
         o_sdio_oe           <= 1'b0;
         o_serial_out_pin    <= 1'b0;
         o_serial_out_pin_oe <= 1'b0;
      end else begin
         o_sdio_out          <= i_read_bit;
         o_serial_out_pin    <= i_read_bit;
         o_sdio_oe           <= i_read_drive & ~o_unidirectional_mode_select;
         o_serial_out_pin_oe <= i_read_drive & o_unidirectional_mode_select;
      end
   end

   // Without the independence bit, B follows the A ratio
   assign ref_b_used = i_ref_b_independent ? ref_b_act_reg : ref_a_act_reg;

   // Reference A divider
   spr_ref_divider #(
      .RATIO_W      (SPR_RATIO_W)
   ) u_div_a (
      .i_clk_sys    (i_clk_sys),
      .i_resetn     (i_resetn),
      .i_soft_reset (soft_reset_reg),
      .i_ref_pin    (i_reference_input_a),
      .i_ratio      (ref_a_act_reg),
      .o_div_pulse  (o_ref_a_div)
   );

   // Reference B divider
   spr_ref_divider #(
      .RATIO_W      (SPR_RATIO_W)
   ) u_div_b (
      .i_clk_sys    (i_clk_sys),
      .i_resetn     (i_resetn),
      .i_soft_reset (soft_reset_reg),
      .i_ref_pin    (i_reference_input_b),
      .i_ratio      (ref_b_used),
      .o_div_pulse  (o_ref_b_div)
   );
endmodule // spr_regs

// ### tb/spr_host_model.sv
// Register-port host model issuing byte writes and reads
module spr_host_model
   import spr_pkg::*;
(
   // Clock and read data
   input  wire logic                  i_clk_sys,
   input  wire logic [7:0]            i_rd_data,
   // Register access strobes
   output logic                       o_wr_en,
   output logic                       o_rd_en,
   output logic      [SPR_ADDR_W-1:0] o_addr,
   output logic      [7:0]            o_wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle strobes from time zero
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr = 12'h000;
      o_wr_data = 8'h00;
   end
   // Byte write; the config byte always carries its mirrored nibble
   task automatic wr(input logic [SPR_ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] b;
      b = d;
      if (a == SPR_OFS_PORT_CFG) b[3:0] = {d[4], d[5], d[6], d[7]};
      @(posedge i_clk_sys);
      o_wr_en <= 1'b1;
      o_addr <= a;
      o_wr_data <= b;
      @(posedge i_clk_sys);
      o_wr_en <= 1'b0;
      o_addr <= ~a; // Released lines show no stale value
      o_wr_data <= ~b;
      #1;
   endtask
   // Byte read; data is registered at the taking edge
   task automatic rd(input logic [SPR_ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_rd_en <= 1'b1;
      o_addr <= a;
      @(posedge i_clk_sys);
      o_rd_en <= 1'b0;
      o_addr <= ~a;
      #1;
      d = i_rd_data;
   endtask
endmodule // spr_host_model

// ### tb/spr_regs_asserts.sv
// Port-level assertions for the register bank
module spr_regs_asserts
   import spr_pkg::*;
(
   // Clock, reset and register port
   input wire logic                   i_clk_sys,
   input wire logic                   i_resetn,
   input wire logic                   i_wr_en,
   input wire logic                   i_rd_en,
   input wire logic [SPR_ADDR_W-1:0]  i_addr,
   input wire logic [7:0]             i_wr_data,
   input wire logic [7:0]             o_rd_data,
   input wire logic                   i_io_update,
   // Modes and pins
   input wire logic                   i_i2c_mode,
   input wire logic                   i_read_drive,
   input wire logic                   o_sdio_oe,
   input wire logic                   o_serial_out_pin_oe,
   input wire logic                   o_unidirectional_mode_select,
   input wire logic                   o_lsb_first,
   input wire logic                   o_soft_reset,
   input wire logic [15:0]            o_user_version_id,
   input wire logic [SPR_RATIO_W-1:0] o_ref_a_ratio
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);
   // Config write, SPI mode held, soft reset not involved
   sequence s_cfg_wr;
      i_wr_en && i_addr == SPR_OFS_PORT_CFG && !i_wr_data[5] && !i_i2c_mode
         && !o_soft_reset ##1 !i_i2c_mode;
   endsequence
   AST_MODE_STORE: assert property (s_cfg_wr |-> o_lsb_first == $past(i_wr_data[6])
      && o_unidirectional_mode_select == $past(i_wr_data[7])) else $error("mode bits lost");
   AST_I2C_GATE: assert property (i_i2c_mode |-> !o_lsb_first
      && !o_unidirectional_mode_select) else $error("mode outputs live in I2C");
   // Soft reset is one cycle high, then low again
   sequence s_soft_pulse;
      o_soft_reset ##1 !o_soft_reset;
   endsequence
   AST_SOFT_PULSE: assert property (i_wr_en && i_addr == SPR_OFS_PORT_CFG && i_wr_data[5]
      && !o_soft_reset |=> s_soft_pulse) else $error("soft reset pulse");
   AST_SOFT_CLEAR: assert property (o_soft_reset |=> o_user_version_id == 16'h0000
      && o_ref_a_ratio == 10'h000) else $error("soft reset left values");
   AST_SDO_OE: assert property (i_read_drive && o_unidirectional_mode_select
      |=> o_serial_out_pin_oe && !o_sdio_oe) else $error("serial out not driven");
   AST_SDIO_OE: assert property (i_read_drive && !o_unidirectional_mode_select
      |=> o_sdio_oe && !o_serial_out_pin_oe) else $error("data pin not driven");
   AST_SHADOW: assert property ($changed(o_ref_a_ratio)
      |-> $past(i_io_update) || $past(o_soft_reset)) else $error("ratio moved without update");
   AST_RD_VER: assert property (i_rd_en && i_addr == SPR_OFS_VER_HIGH && !o_soft_reset
      |=> o_rd_data == $past(o_user_version_id[15:8])) else $error("version read wrong");
endmodule // spr_regs_asserts
bind spr_regs spr_regs_asserts u_chk (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
   .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
   .i_io_update(i_io_update), .i_i2c_mode(i_i2c_mode), .i_read_drive(i_read_drive),
   .o_sdio_oe(o_sdio_oe), .o_serial_out_pin_oe(o_serial_out_pin_oe),
   .o_unidirectional_mode_select(o_unidirectional_mode_select), .o_lsb_first(o_lsb_first),
   .o_soft_reset(o_soft_reset), .o_user_version_id(o_user_version_id),
   .o_ref_a_ratio(o_ref_a_ratio));

// ### tb/tb_spr_regs.sv
// Self-checking bench for the register bank
module tb_spr_regs
   import spr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Design pins and bench state
   logic i_clk_sys, i_resetn, i_wr_en, i_rd_en, i_io_update, i_i2c_mode, i_read_drive;
   logic i_ref_b_independent, i_read_bit, i_reference_input_a, i_reference_input_b;
   logic o_sdio_out, o_sdio_oe, o_serial_out_pin, o_serial_out_pin_oe, o_soft_reset;
   logic o_unidirectional_mode_select, o_lsb_first, o_ref_a_div, o_ref_b_div;
   logic [SPR_ADDR_W-1:0] i_addr;
   logic [7:0] i_wr_data, o_rd_data, rd_v;
   logic [15:0] o_user_version_id;
   logic [SPR_RATIO_W-1:0] o_ref_a_ratio, o_ref_b_ratio;
   int bad_count, comparisons, cycles, pulses_a, pulses_b;
   spr_regs DUT (
      .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
      .i_io_update(i_io_update), .i_i2c_mode(i_i2c_mode),
      .i_ref_b_independent(i_ref_b_independent), .i_read_drive(i_read_drive),
      .i_read_bit(i_read_bit), .o_sdio_out(o_sdio_out), .o_sdio_oe(o_sdio_oe),
      .o_serial_out_pin(o_serial_out_pin), .o_serial_out_pin_oe(o_serial_out_pin_oe),
      .o_unidirectional_mode_select(o_unidirectional_mode_select),
      .o_lsb_first(o_lsb_first), .o_soft_reset(o_soft_reset),
      .o_user_version_id(o_user_version_id), .i_reference_input_a(i_reference_input_a),
      .i_reference_input_b(i_reference_input_b), .o_ref_a_ratio(o_ref_a_ratio),
      .o_ref_b_ratio(o_ref_b_ratio), .o_ref_a_div(o_ref_a_div), .o_ref_b_div(o_ref_b_div));
   spr_host_model host (.i_clk_sys(i_clk_sys), .i_rd_data(o_rd_data), .o_wr_en(i_wr_en),
      .o_rd_en(i_rd_en), .o_addr(i_addr), .o_wr_data(i_wr_data));
   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   // Pulse tallies and hang guard, far above the expected run length
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      pulses_a <= pulses_a + o_ref_a_div;
      pulses_b <= pulses_b + o_ref_b_div;
      if (cycles == 5000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic upd();
      @(posedge i_clk_sys);
      i_io_update <= 1'b1;
      @(posedge i_clk_sys);
      i_io_update <= 1'b0;
      #1;
   endtask
   // Twelve reference cycles, each level three clocks long
   task automatic edges(input int ea, input int eb);
      int pa, pb;
      #1;
      pa = pulses_a;
      pb = pulses_b;
      repeat (12) begin
         repeat (3) @(posedge i_clk_sys);
         i_reference_input_a <= 1'b1;
         i_reference_input_b <= 1'b1;
         repeat (3) @(posedge i_clk_sys);
         i_reference_input_a <= 1'b0;
         i_reference_input_b <= 1'b0;
      end
      repeat (8) @(posedge i_clk_sys);
      check("pulses a", 16'(pulses_a - pa), 16'(ea));
      check("pulses b", 16'(pulses_b - pb), 16'(eb));
   endtask
   task automatic t_defaults();
      logic [11:0] a [9] = '{12'h000, 12'h004, 12'h005, 12'h006, 12'h010, 12'h011, 12'h012,
         12'h013, 12'h007};
      foreach (a[k]) begin
         host.rd(a[k], rd_v);
         check("reset read", rd_v, 8'h00);
      end
      $display("t_defaults done");
   endtask
   task automatic t_cfg();
      @(posedge i_clk_sys);
      i_read_drive <= 1'b1;
      i_read_bit <= 1'b1;
      host.wr(SPR_OFS_PORT_CFG, 8'hc0);
      host.rd(SPR_OFS_PORT_CFG, rd_v);
      check("cfg read", rd_v, 8'hc3);
      check("lsb first", o_lsb_first, 1'b1);
      check("pins", {o_serial_out_pin_oe, o_sdio_oe, o_serial_out_pin, o_sdio_out}, 4'b1011);
      @(posedge i_clk_sys);
      i_i2c_mode <= 1'b1;
      #1 check("i2c", {o_unidirectional_mode_select, o_lsb_first}, 2'b00);
      @(posedge i_clk_sys);
      i_i2c_mode <= 1'b0;
      $display("t_cfg done");
   endtask
   task automatic t_ratios();
      host.wr(SPR_OFS_VER_LOW, 8'h34);
      host.wr(SPR_OFS_VER_HIGH, 8'h12);
      check("version", o_user_version_id, 16'h1234);
      host.rd(SPR_OFS_VER_HIGH, rd_v);
      check("version high", rd_v, 8'h12);
      host.wr(SPR_OFS_REF_A_LOW, 8'hff);
      host.wr(SPR_OFS_REF_A_HIGH, 8'hff);
      host.wr(SPR_OFS_REF_B_HIGH, 8'h02);
      host.rd(SPR_OFS_REF_A_LOW, rd_v);
      check("active a", rd_v, 8'h00);
      host.wr(SPR_OFS_READBACK, 8'h01);
      host.rd(SPR_OFS_REF_A_HIGH, rd_v);
      check("shadow a", rd_v, 8'h03);
      upd();
      check("ratio a", o_ref_a_ratio, 10'h3ff);
      check("ratio b", o_ref_b_ratio, 10'h200);
      $display("t_ratios done");
   endtask
   task automatic t_divide();
      host.wr(SPR_OFS_REF_A_LOW, 8'h00);
      host.wr(SPR_OFS_REF_A_HIGH, 8'h00);
      upd();
      edges(12, 12);
      host.wr(SPR_OFS_REF_A_LOW, 8'h01);
      upd();
      edges(12, 12);
      host.wr(SPR_OFS_REF_A_LOW, 8'h03);
      upd();
      edges(4, 4);
      host.wr(SPR_OFS_REF_B_LOW, 8'h02);
      host.wr(SPR_OFS_REF_B_HIGH, 8'h00);
      @(posedge i_clk_sys);
      i_ref_b_independent <= 1'b1;
      upd();
      edges(4, 6);
      $display("t_divide done");
   endtask
   task automatic t_soft();
      host.wr(SPR_OFS_PORT_CFG, 8'h20);
      check("soft pulse", o_soft_reset, 1'b1);
      host.rd(SPR_OFS_VER_LOW, rd_v);
      check("soft self clear", o_soft_reset, 1'b0);
      check("soft version", rd_v, 8'h00);
      host.rd(SPR_OFS_PORT_CFG, rd_v);
      check("soft cfg", rd_v, 8'h00);
      check("soft ratio", o_ref_b_ratio, 10'h000);
      $display("t_soft done");
   endtask
   initial begin
      {i_resetn, i_io_update, i_i2c_mode, i_read_drive, i_read_bit} = 5'h00;
      {i_ref_b_independent, i_reference_input_a, i_reference_input_b} = 3'h0;
      repeat (5) @(posedge i_clk_sys);
      i_resetn <= 1'b1;
      t_defaults();
      t_cfg();
      t_ratios();
      t_divide();
      t_soft();
      test_done();
   end
endmodule // tb_spr_regs
